// ### src/ohsp_consts.vh
// Timing, framing and counter constants for the overhead serial ports
`ifndef OHSP_CONSTS_VH
`define OHSP_CONSTS_VH

// Master clock rate in kHz (50 MHz)
`define OHSP_MCLK_KHZ 64'd50000
// Phase increment for a 24-bit accumulator toggling at twice the rate
`define OHSP_INC(khz) (((khz) * 64'd33554432) / `OHSP_MCLK_KHZ)

// Port clock rates in kHz
`define OHSP_OVH_KHZ 64'd1408
`define OHSP_RING_KHZ 64'd648
`define OHSP_SEC_KHZ 64'd192
`define OHSP_LINE_KHZ 64'd576

// Bits per 125 us frame and counter widths
`define OHSP_OVH_BITS 176
`define OHSP_OVH_CW 8
`define OHSP_RING_BITS 81
`define OHSP_RING_CW 7
`define OHSP_SEC_BITS 24
`define OHSP_SEC_CW 5
`define OHSP_LINE_BITS 72
`define OHSP_LINE_CW 7

// Frame pulse positions
`define OHSP_OVH_LAST 8'hAF
`define OHSP_RING_FR_BIT 7'h08
`define OHSP_RING_PAY_BYTES 4'h9

// Ring framing sequence and receive bit timing
`define OHSP_RING_FSEQ 8'hF6
`define OHSP_RING_BIT_CYC 7'h4D
`define OHSP_RING_MID 7'h26
`define OHSP_RING_PAY_LAST 7'h47

// Ring receive states
`define OHSP_RX_HUNT 1'b0
`define OHSP_RX_RECV 1'b1

`endif

// ### src/ohsp_lane.v
// One serial lane: averaged port clock, bit counter, shifter out and in
`timescale 1ns/1ns
module ohsp_lane #(
  parameter [63:0] INC = 64'h0000000000000001,
  parameter integer FBITS = 8,
  parameter integer CW = 4,
  parameter integer FALL_LAUNCH = 0
) (
  input wire mclk,
  input wire rstn,
  input wire [7:0] byte_in,
  input wire ser_in,
  output reg clk_out,
  output reg ser_out,
  output reg [CW-1:0] cnt,
  output wire step,
  output wire rise_ev,
  output wire fall_ev,
  output reg [7:0] byte_out,
  output reg byte_valid,
  output reg [CW-4:0] byte_idx
);
  localparam integer LASTI = FBITS - 1;
  localparam [CW-1:0] LAST = LASTI[CW-1:0];

  reg [23:0] acc;
  reg [7:0] sh;
  reg [6:0] cap;
  wire [24:0] sum = {1'b0, acc} + {1'b0, INC[23:0]};

  // Carry of the accumulator marks a half period of the port clock
  assign rise_ev = sum[24] & ~clk_out;
  assign fall_ev = sum[24] & clk_out;
  assign step = (FALL_LAUNCH != 0) ? fall_ev : rise_ev;

  // Port clock; edges jitter by one mclk but the average rate is exact
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc <= 24'h000000;
      clk_out <= 1'b0;
    end else begin
      acc <= sum[23:0];
      clk_out <= clk_out ^ sum[24];
    end
  end

  // Frame bit counter and MSB-first shifter on the launch edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= {CW{1'b0}};
      ser_out <= 1'b0;
      sh <= 8'h00;
    end else if (step) begin
      cnt <= (cnt == LAST) ? {CW{1'b0}} : cnt + 1'b1;
      if (cnt[2:0] == 3'h0) begin
        ser_out <= byte_in[7]; // R15
        sh <= {byte_in[6:0], 1'b0};
      end else begin
        ser_out <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end
    end
  end

  // Sampling side gathers bits MSB first on the rising edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap <= 7'h00;
      byte_out <= 8'h00;
      byte_valid <= 1'b0;
      byte_idx <= {(CW-3){1'b0}};
    end else begin
      byte_valid <= 1'b0;
      if (rise_ev) begin
        cap <= {cap[5:0], ser_in}; // R2
        if (cnt[2:0] == 3'h7) begin
          byte_out <= {cap, ser_in}; // R15
          byte_valid <= 1'b1;
          byte_idx <= cnt[CW-1:3];
        end
      end
    end
  end
endmodule // ohsp_lane

// ### src/ohsp_top.v
// Overhead, ring and data-channel serial ports of the overhead terminator
// Behaviour
// R1: The incoming overhead port gets a 1.408 MHz average device clock.
// R2: Incoming overhead bits are sampled on rising edges of that clock.
// R3: Its low frame pulse leaves on a falling edge 1.5 cycles before C1 MSB.
// R4: The outgoing overhead port gets a 1.408 MHz average device clock.
// R5: Outgoing overhead bits change on rising edges of that clock.
// R6: Its low frame pulse leaves on a rising edge one cycle before C1 MSB.
// R7: The ring port has a 648 kHz clock timing its data and frame outputs.
// R8: The low ring frame pulse follows right after the framing sequence.
// R9: Ring output data changes on each rising edge of the ring clock.
// R10: Ring input has no clock; bit timing is recovered from the data.
// R11: Section channel receive bytes leave at 192 kbit/s on falling edges.
// R12: Line channel receive bytes leave at 576 kbit/s on falling edges.
// R13: Section channel transmit bytes are sampled on rising 192 kHz edges.
// R14: Line channel transmit bytes are sampled on rising 576 kHz edges.
// R15: Every serial port carries each byte most significant bit first.
// R16: The far end samples receive channel data on the rising clock edge.
`timescale 1ns/1ns
`include "ohsp_consts.vh"
module ohsp_top (
  input wire mclk,
  input wire rstn,
  output wire ovh_in_port_clock,
  input wire ovh_in_port_data,
  output reg ovh_in_port_frame_n,
  output wire [7:0] ovh_in_byte,
  output wire ovh_in_byte_valid,
  output wire [4:0] ovh_in_byte_index,
  output wire ovh_out_port_clock,
  output wire ovh_out_port_data,
  output reg ovh_out_port_frame_n,
  input wire [7:0] ovh_out_byte,
  output reg [4:0] ovh_out_byte_index,
  output wire ring_port_clock,
  output reg ring_port_frame_n,
  output wire ring_port_data_out,
  input wire ring_port_data_in,
  input wire [7:0] ring_tx_byte,
  output reg [3:0] ring_tx_byte_index,
  output reg [7:0] ring_rx_byte,
  output reg ring_rx_byte_valid,
  output reg ring_rx_frame,
  output wire rx_section_chan_clock,
  output wire rx_section_chan_data,
  input wire [7:0] rx_section_byte,
  output reg [1:0] rx_section_byte_index,
  output wire rx_line_chan_clock,
  output wire rx_line_chan_data,
  input wire [7:0] rx_line_byte,
  output reg [3:0] rx_line_byte_index,
  output wire tx_section_chan_clock,
  input wire tx_section_chan_data,
  output wire [7:0] tx_section_byte,
  output wire tx_section_byte_valid,
  output wire [1:0] tx_section_byte_index,
  output wire tx_line_chan_clock,
  input wire tx_line_chan_data,
  output wire [7:0] tx_line_byte,
  output wire tx_line_byte_valid,
  output wire [3:0] tx_line_byte_index
);
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg ring_prev;
  reg [6:0] ring_phase;
  reg [7:0] ring_hunt;
  reg [6:0] ring_bitc;
  reg ring_state;
  reg [7:0] ring_load;
  wire [7:0] ovi_cnt;
  wire [7:0] ovo_cnt;
  wire [6:0] ring_cnt;
  wire [4:0] rxs_cnt;
  wire [6:0] rxl_cnt;
  wire ovi_fall;
  wire ovo_step;
  wire ring_step;
  wire ring_bit;

  // Pins from outside pass two flops; first stage feeds only the second
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {ring_port_data_in, tx_line_chan_data,
                tx_section_chan_data, ovh_in_port_data};
      sync2 <= sync1;
    end
  end

  // Incoming overhead port: device clock, sample on rise
  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_OVH_KHZ)), // R1
    .FBITS(`OHSP_OVH_BITS),
    .CW(`OHSP_OVH_CW),
    .FALL_LAUNCH(0)
  ) u_ovh_in (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(8'h00),
    .ser_in(sync2[0]), // R2
    .clk_out(ovh_in_port_clock),
    .ser_out(),
    .cnt(ovi_cnt),
    .step(),
    .rise_ev(),
    .fall_ev(ovi_fall),
    .byte_out(ovh_in_byte),
    .byte_valid(ovh_in_byte_valid),
    .byte_idx(ovh_in_byte_index)
  );

  // Outgoing overhead port: data changes on rise
  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_OVH_KHZ)), // R4
    .FBITS(`OHSP_OVH_BITS),
    .CW(`OHSP_OVH_CW),
    .FALL_LAUNCH(0) // R5
  ) u_ovh_out (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(ovh_out_byte),
    .ser_in(ovh_out_port_data), // Own output looped; capture side unused
    .clk_out(ovh_out_port_clock),
    .ser_out(ovh_out_port_data),
    .cnt(ovo_cnt),
    .step(ovo_step),
    .rise_ev(),
    .fall_ev(),
    .byte_out(),
    .byte_valid(),
    .byte_idx()
  );

  // Ring transmit: framing byte, then payload bytes, then a zero pad bit
  always @* begin
    if (ring_cnt[6:3] == 4'h0) begin
      ring_load = `OHSP_RING_FSEQ;
    end else if (ring_cnt[6:3] <= `OHSP_RING_PAY_BYTES) begin
      ring_load = ring_tx_byte;
    end else begin
      ring_load = 8'h00;
    end
  end

  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_RING_KHZ)), // R7
    .FBITS(`OHSP_RING_BITS),
    .CW(`OHSP_RING_CW),
    .FALL_LAUNCH(0) // R9
  ) u_ring (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(ring_load),
    .ser_in(ring_port_data_out),
    .clk_out(ring_port_clock),
    .ser_out(ring_port_data_out),
    .cnt(ring_cnt),
    .step(ring_step),
    .rise_ev(),
    .fall_ev(),
    .byte_out(),
    .byte_valid(),
    .byte_idx()
  );

  // Receive data channels: data launched on the falling edge
  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_SEC_KHZ)),
    .FBITS(`OHSP_SEC_BITS),
    .CW(`OHSP_SEC_CW),
    .FALL_LAUNCH(1) // R11
  ) u_rx_sec (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(rx_section_byte),
    .ser_in(rx_section_chan_data),
    .clk_out(rx_section_chan_clock),
    .ser_out(rx_section_chan_data),
    .cnt(rxs_cnt),
    .step(),
    .rise_ev(),
    .fall_ev(),
    .byte_out(),
    .byte_valid(),
    .byte_idx()
  );

  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_LINE_KHZ)),
    .FBITS(`OHSP_LINE_BITS),
    .CW(`OHSP_LINE_CW),
    .FALL_LAUNCH(1) // R12
  ) u_rx_line (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(rx_line_byte),
    .ser_in(rx_line_chan_data),
    .clk_out(rx_line_chan_clock),
    .ser_out(rx_line_chan_data),
    .cnt(rxl_cnt),
    .step(),
    .rise_ev(),
    .fall_ev(),
    .byte_out(),
    .byte_valid(),
    .byte_idx()
  );

  // Transmit data channels: far end sources, device samples on rise
  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_SEC_KHZ)),
    .FBITS(`OHSP_SEC_BITS),
    .CW(`OHSP_SEC_CW),
    .FALL_LAUNCH(0)
  ) u_tx_sec (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(8'h00),
    .ser_in(sync2[1]), // R13
    .clk_out(tx_section_chan_clock),
    .ser_out(),
    .cnt(),
    .step(),
    .rise_ev(),
    .fall_ev(),
    .byte_out(tx_section_byte),
    .byte_valid(tx_section_byte_valid),
    .byte_idx(tx_section_byte_index)
  );

  ohsp_lane #(
    .INC(`OHSP_INC(`OHSP_LINE_KHZ)),
    .FBITS(`OHSP_LINE_BITS),
    .CW(`OHSP_LINE_CW),
    .FALL_LAUNCH(0)
  ) u_tx_line (
    .mclk(mclk),
    .rstn(rstn),
    .byte_in(8'h00),
    .ser_in(sync2[2]), // R14
    .clk_out(tx_line_chan_clock),
    .ser_out(),
    .cnt(),
    .step(),
    .rise_ev(),
    .fall_ev(),
    .byte_out(tx_line_byte),
    .byte_valid(tx_line_byte_valid),
    .byte_idx(tx_line_byte_index)
  );

  // Frame pulses, each one port clock period wide
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovh_in_port_frame_n <= 1'b1;
      ovh_out_port_frame_n <= 1'b1;
      ring_port_frame_n <= 1'b1;
    end else begin
      if (ovi_fall) begin
        ovh_in_port_frame_n <= ~(ovi_cnt == `OHSP_OVH_LAST); // R3
      end
      if (ovo_step) begin
        ovh_out_port_frame_n <= ~(ovo_cnt == `OHSP_OVH_LAST); // R6
      end
      if (ring_step) begin
        ring_port_frame_n <= ~(ring_cnt == `OHSP_RING_FR_BIT); // R8
      end
    end
  end

  // Byte selects shown to the user, one mclk behind the bit counters;
  // counters hold for many mclk so the byte is settled before its load
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovh_out_byte_index <= 5'h00;
      ring_tx_byte_index <= 4'h0;
      rx_section_byte_index <= 2'h0;
      rx_line_byte_index <= 4'h0;
    end else begin
      ovh_out_byte_index <= ovo_cnt[7:3];
      ring_tx_byte_index <= ring_cnt[6:3] - 4'h1;
      rx_section_byte_index <= rxs_cnt[4:3];
      rx_line_byte_index <= rxl_cnt[6:3];
    end
  end

  // Ring input bit recovery: realign phase on every data transition
  assign ring_bit = sync2[3];
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ring_prev <= 1'b0;
      ring_phase <= 7'h00;
    end else begin
      ring_prev <= ring_bit;
      if (ring_bit != ring_prev) begin
        ring_phase <= 7'h00; // R10
      end else if (ring_phase == `OHSP_RING_BIT_CYC - 7'h01) begin
        ring_phase <= 7'h00;
      end else begin
        ring_phase <= ring_phase + 7'h01;
      end
    end
  end

  // Ring input framer: hunt for the sequence, then collect payload bytes
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ring_state <= `OHSP_RX_HUNT;
      ring_hunt <= 8'h00;
      ring_bitc <= 7'h00;
      ring_rx_byte <= 8'h00;
      ring_rx_byte_valid <= 1'b0;
      ring_rx_frame <= 1'b0;
    end else begin
      ring_rx_byte_valid <= 1'b0;
      ring_rx_frame <= 1'b0;
      if (ring_phase == `OHSP_RING_MID) begin
        ring_hunt <= {ring_hunt[6:0], ring_bit}; // R10
        case (ring_state)
          `OHSP_RX_HUNT: begin
            if ({ring_hunt[6:0], ring_bit} == `OHSP_RING_FSEQ) begin
              ring_state <= `OHSP_RX_RECV;
              ring_bitc <= 7'h00;
              ring_rx_frame <= 1'b1;
            end
          end
          `OHSP_RX_RECV: begin
            ring_bitc <= ring_bitc + 7'h01;
            if (ring_bitc[2:0] == 3'h7) begin
              ring_rx_byte <= {ring_hunt[6:0], ring_bit}; // R15
              ring_rx_byte_valid <= 1'b1;
            end
            if (ring_bitc == `OHSP_RING_PAY_LAST) begin
              ring_state <= `OHSP_RX_HUNT;
            end
          end
          default: begin
            ring_state <= `OHSP_RX_HUNT;
          end
        endcase
      end
    end
  end
endmodule // ohsp_top

// ### tb/ohsp_top_monitor.sv
// Port timing checker for the overhead serial ports
`timescale 1ns/1ns
module ohsp_top_monitor (
  input wire mclk,
  input wire rstn,
  input wire ovh_in_port_clock,
  input wire ovh_in_port_frame_n,
  input wire ovh_out_port_clock,
  input wire ovh_out_port_data,
  input wire ovh_out_port_frame_n,
  input wire ring_port_clock,
  input wire ring_port_frame_n,
  input wire ring_port_data_out,
  input wire ring_rx_frame,
  input wire rx_section_chan_clock,
  input wire rx_section_chan_data,
  input wire rx_line_chan_clock,
  input wire rx_line_chan_data,
  input wire tx_section_chan_clock,
  input wire tx_line_chan_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Pin edges are tied to the port clock edge that launches them
  AST_OI_FR_EDGE: assert property ($changed(ovh_in_port_frame_n) |->
    $fell(ovh_in_port_clock)) else $error("oi frame edge");
  AST_OI_FR_WIDTH: assert property ($fell(ovh_in_port_frame_n) |->
    ##[34:36] $rose(ovh_in_port_frame_n)) else $error("oi frame width");
  AST_OI_HALF: assert property ($rose(ovh_in_port_clock) |->
    ##[17:18] $fell(ovh_in_port_clock)) else $error("oi clock rate");
  AST_OO_DATA_EDGE: assert property ($changed(ovh_out_port_data) |->
    $rose(ovh_out_port_clock)) else $error("oo data edge");
  AST_OO_FR_EDGE: assert property ($changed(ovh_out_port_frame_n) |->
    $rose(ovh_out_port_clock)) else $error("oo frame edge");
  AST_RING_EDGE: assert property ($changed(ring_port_data_out) ||
    $changed(ring_port_frame_n) |-> $rose(ring_port_clock))
    else $error("ring edge");
  AST_RING_FR_WIDTH: assert property ($fell(ring_port_frame_n) |->
    ##[76:78] $rose(ring_port_frame_n)) else $error("ring frame width");
  // Looped framing byte is found about half a ring bit before the pulse
  AST_RING_FR_POS: assert property ($rose(ring_rx_frame) |->
    ##[30:40] $fell(ring_port_frame_n)) else $error("ring frame place");
  AST_RING_HALF: assert property ($rose(ring_port_clock) |->
    ##[38:39] $fell(ring_port_clock)) else $error("ring clock rate");
  AST_SR_EDGE: assert property ($changed(rx_section_chan_data) |->
    $fell(rx_section_chan_clock)) else $error("sec data edge");
  AST_LR_EDGE: assert property ($changed(rx_line_chan_data) |->
    $fell(rx_line_chan_clock)) else $error("line data edge");
  AST_ST_HALF: assert property ($rose(tx_section_chan_clock) |->
    ##[130:131] $fell(tx_section_chan_clock)) else $error("sec rate");
  AST_LT_HALF: assert property ($rose(tx_line_chan_clock) |->
    ##[43:44] $fell(tx_line_chan_clock)) else $error("line rate");
  // Main scenarios reached
  cover property ($fell(ovh_in_port_frame_n));
  cover property ($fell(ovh_out_port_frame_n));
  cover property ($rose(ring_rx_frame));
endmodule // ohsp_top_monitor

bind ohsp_top ohsp_top_monitor u_ohsp_top_monitor (
  .mclk, .rstn, .ovh_in_port_clock, .ovh_in_port_frame_n,
  .ovh_out_port_clock, .ovh_out_port_data, .ovh_out_port_frame_n,
  .ring_port_clock, .ring_port_frame_n, .ring_port_data_out,
  .ring_rx_frame, .rx_section_chan_clock, .rx_section_chan_data,
  .rx_line_chan_clock, .rx_line_chan_data, .tx_section_chan_clock,
  .tx_line_chan_clock
);

// ### tb/ohsp_far_end.sv
// Far-end serial source and receiver models for the overhead ports
`timescale 1ns/1ns
module ohsp_ser_src #(
  parameter integer N = 8
) (
  input wire mclk,
  input wire rstn,
  input wire pclk,
  input wire fr_n,
  output reg dout
);
  reg pclk_d;
  reg fr_d;
  reg [7:0] b;
  integer cnt;
  // Moves a bit after each clock fall so it is steady at the next rise
  always @(negedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt = 0;
      fr_d = 1'b1;
    end else if (pclk_d && !pclk) begin
      cnt = (!fr_d || cnt == N - 1) ? 0 : cnt + 1;
      fr_d = fr_n;
    end
    pclk_d = pclk;
    b = 8'hC4 ^ cnt[10:3];
    dout = b[7 - cnt[2:0]];
  end
endmodule // ohsp_ser_src

module ohsp_ser_snk #(
  parameter integer N = 8,
  parameter integer RISE = 1,
  parameter integer FIRST = -2
) (
  input wire mclk,
  input wire rstn,
  input wire pclk,
  input wire fr_n,
  input wire din,
  output reg [7:0] sb,
  output reg got,
  output reg [4:0] idx
);
  reg pclk_d;
  reg fr_d;
  reg [7:0] sr;
  integer cnt;
  // Samples half a port period after the data moves, away from the edge
  always @(posedge mclk or negedge rstn) begin
    got <= 1'b0;
    if (!rstn) begin
      cnt = FIRST;
      fr_d = 1'b1;
    end else if (pclk !== pclk_d && pclk == RISE) begin
      cnt = (!fr_d || cnt == N - 1) ? 0 : cnt + 1;
      fr_d = fr_n;
      sr = {sr[6:0], din};
      if (cnt >= 0 && cnt[2:0] == 3'h7) begin
        sb <= sr;
        got <= 1'b1;
        idx <= cnt[7:3];
      end
    end
    pclk_d = pclk;
  end
endmodule // ohsp_ser_snk

// ### tb/ohsp_top_test.sv
// Self-checking bench for the overhead serial ports
`timescale 1ns/1ns
module ohsp_top_test;
  reg mclk;
  reg rstn;
  reg [7:0] ovh_out_byte, ring_tx_byte, rx_section_byte, rx_line_byte;
  wire ovh_in_port_clock, ovh_in_port_data, ovh_in_port_frame_n;
  wire ovh_in_byte_valid, ovh_out_port_clock, ovh_out_port_data;
  wire ovh_out_port_frame_n, ring_port_clock, ring_port_frame_n;
  wire ring_port_data_out, ring_port_data_in, ring_rx_byte_valid;
  wire ring_rx_frame, rx_section_chan_clock, rx_section_chan_data;
  wire rx_line_chan_clock, rx_line_chan_data, tx_section_chan_clock;
  wire tx_section_chan_data, tx_section_byte_valid, tx_line_chan_clock;
  wire tx_line_chan_data, tx_line_byte_valid, oo_g, sr_g, lr_g;
  wire [7:0] ovh_in_byte, ring_rx_byte, tx_section_byte, tx_line_byte;
  wire [7:0] oo_b, sr_b, lr_b;
  wire [4:0] ovh_in_byte_index, ovh_out_byte_index, oo_i, sr_i, lr_i;
  wire [3:0] ring_tx_byte_index, rx_line_byte_index, tx_line_byte_index;
  wire [1:0] rx_section_byte_index, tx_section_byte_index;
  int n_mismatch = 0;
  int compares = 0;
  // Streams packed side by side so one task can walk any of them
  wire [47:0] s_b = {lr_b, sr_b, oo_b, tx_line_byte, tx_section_byte,
    ovh_in_byte};
  wire [5:0] s_v = {lr_g, sr_g, oo_g, tx_line_byte_valid,
    tx_section_byte_valid, ovh_in_byte_valid};
  wire [29:0] s_i = {lr_i, sr_i, oo_i, 1'b0, tx_line_byte_index, 3'h0,
    tx_section_byte_index, ovh_in_byte_index};

  ohsp_top u_ohsp_top (.*);
  // Peer ring device simply returns what it hears; no clock goes back
  assign ring_port_data_in = ring_port_data_out;
  ohsp_ser_src #(.N(176)) u_ohsp_ser_src_ovh (.mclk(mclk), .rstn(rstn),
    .pclk(ovh_in_port_clock), .fr_n(ovh_in_port_frame_n),
    .dout(ovh_in_port_data));
  // Data channels carry no frame pulse; the marker idles once out of reset
  ohsp_ser_src #(.N(24)) u_ohsp_ser_src_sec (.mclk(mclk), .rstn(rstn),
    .pclk(tx_section_chan_clock), .fr_n(rstn), .dout(tx_section_chan_data));
  ohsp_ser_src #(.N(72)) u_ohsp_ser_src_line (.mclk(mclk), .rstn(rstn),
    .pclk(tx_line_chan_clock), .fr_n(rstn), .dout(tx_line_chan_data));
  ohsp_ser_snk #(.N(176), .RISE(0), .FIRST(-1)) u_ohsp_ser_snk_ovh (
    .mclk(mclk), .rstn(rstn), .pclk(ovh_out_port_clock),
    .fr_n(ovh_out_port_frame_n), .din(ovh_out_port_data),
    .sb(oo_b), .got(oo_g), .idx(oo_i));
  ohsp_ser_snk #(.N(24)) u_ohsp_ser_snk_sec (.mclk(mclk), .rstn(rstn),
    .pclk(rx_section_chan_clock), .fr_n(rstn), .din(rx_section_chan_data),
    .sb(sr_b), .got(sr_g), .idx(sr_i));
  ohsp_ser_snk #(.N(72)) u_ohsp_ser_snk_line (.mclk(mclk), .rstn(rstn),
    .pclk(rx_line_chan_clock), .fr_n(rstn), .din(rx_line_chan_data),
    .sb(lr_b), .got(lr_g), .idx(lr_i));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Byte sources follow the index the block asks for
  always @(negedge mclk) begin
    ovh_out_byte <= 8'hC4 ^ {3'h0, ovh_out_byte_index};
    ring_tx_byte <= 8'hC4 ^ {4'h0, ring_tx_byte_index};
    rx_section_byte <= 8'hC4 ^ {6'h00, rx_section_byte_index};
    rx_line_byte <= 8'hC4 ^ {4'h0, rx_line_byte_index};
  end

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for each byte of a stream; index must wrap at the frame length
  task automatic run_stream(input int s, input int n, input int nb,
    input string what);
    int t;
    logic [4:0] k;
    logic [4:0] kp;
    for (int i = 0; i < n; i++) begin
      for (t = 0; t < 20000 && s_v[s] !== 1'b1; t++) @(negedge mclk);
      check({what, " valid"}, {7'h00, s_v[s]}, 8'h01);
      k = s_i[s*5 +: 5];
      check(what, s_b[s*8 +: 8], 8'hC4 ^ {3'h0, k});
      kp = (kp == nb - 1) ? 5'h00 : kp + 5'h01;
      if (i > 0) check({what, " index"}, {3'h0, k}, {3'h0, kp});
      kp = k;
      @(negedge mclk);
    end
  endtask

  // Both overhead byte ports across a frame wrap
  task automatic t_ovh;
    fork
      run_stream(0, 24, 22, "ovh_in");
      run_stream(3, 24, 22, "ovh_out");
    join
  endtask

  // All four data-channel streams
  task automatic t_chan;
    fork
      run_stream(1, 4, 3, "tx_sec");
      run_stream(2, 10, 9, "tx_line");
      run_stream(4, 4, 3, "rx_sec");
      run_stream(5, 10, 9, "rx_line");
    join
  endtask

  // Ring frame found in the looped data, then the nine payload bytes
  task automatic t_ring;
    int t;
    for (t = 0; t < 20000 && ring_rx_frame !== 1'b1; t++) @(negedge mclk);
    check("ring frame", {7'h00, ring_rx_frame}, 8'h01);
    for (int k = 0; k < 9; k++) begin
      for (t = 0; t < 2000 && ring_rx_byte_valid !== 1'b1; t++)
        @(negedge mclk);
      check("ring byte", ring_rx_byte, 8'hC4 ^ k[7:0]);
      @(negedge mclk);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    fork
      t_ovh();
      t_chan();
      t_ring();
    join
    end_of_test();
  end

  // A run needs under a frame and a half; this is well beyond that
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
endmodule // ohsp_top_test
